// ---- design/usbbrm_core.sv ----
// usb buffer ram, descriptor table lookup, regulator and pull-up control
//
// Contract
// - cpu ram accesses to ram, others to engine
// - arbiter gives ram to cpu and engine
// - 256-byte ram readable and writable by both; engine data port writes only reach 0x20-0xff
// - ram runs two slots per bus clock
// - free ram usable; disabled gives cpu all
// - each descriptor is three consecutive bytes
// - own clear: cpu owns descriptor and buffer
// - own set: engine owns; cpu leaves alone
// - endpoint zero has in and out descriptors
// - double buffered: even then odd descriptor
// - descriptor table fixed at 0x00 to 0x1d
// - order ep0 in, out, ep1-4, ep5, ep6
// - 0x1e-0x1f reserved, 0x20-0xff data buffers
// - token fetches descriptor, checks own first
// - completion writes own back to zero
// - regulator standby on suspend, else active
// - regulator off in deep stop or disabled
// - pull-up enable switches internal d-plus pull-up
`timescale 1ns/1ps
`include "usbbrm_regs.svh"
module usbbrm_core (
   input wire logic mclk, // bus clock, 10 mhz
   input wire logic arst_n, // async reset, active low
   input wire logic usb_enable, // usb module enabled
   input wire logic cpu_req, // cpu access strobe
   input wire logic cpu_we, // cpu write
   input wire logic [8:0] cpu_addr, // bit 8 selects registers
   input wire logic [7:0] cpu_wdata, // cpu write data
   output logic [7:0] cpu_rdata, // cpu read data, next cycle
   output logic reg_sel, // access to engine registers
   output logic reg_we, // engine register write
   output logic [7:0] reg_addr, // engine register offset
   output logic [7:0] reg_wdata, // engine register data
   input wire logic [7:0] reg_rdata, // engine register read data
   input wire logic tok_valid, // token received
   input wire logic [2:0] tok_ep, // token endpoint
   input wire logic tok_in, // token is in direction
   input wire logic tok_odd, // odd buffer for ep5/ep6
   input wire logic [6:0] ep_en, // endpoint enables
   output logic tok_ready, // token taken when high
   output logic bd_valid, // descriptor result, one cycle
   output logic bd_own, // engine owns descriptor
   output logic bd_stall, // descriptor asks for stall
   output logic bd_addr_ok, // buffer lies in data area
   output logic [7:0] bd_status, // descriptor status byte
   output logic [7:0] bd_count, // descriptor byte count
   output logic [7:0] bd_addr, // buffer byte address
   output logic se_ready, // data port open
   input wire logic se_req, // engine data access
   input wire logic se_we, // engine data write
   input wire logic [7:0] se_addr, // engine data address
   input wire logic [7:0] se_wdata, // engine write data
   output logic [7:0] se_rdata, // engine read data, next cycle
   input wire logic tok_done, // token finished, release
   input wire logic [7:0] done_count, // received byte count
   input wire logic usb_regulator_enable, // regulator enabled
   input wire logic usb_suspend, // device in suspend
   input wire logic deep_stop, // deep stop mode entered
   input wire logic internal_pullup_enable, // pull-up bit
   output logic [2:0] usb_regulator_mode, // regulator mode, one-hot
   output logic dp_pullup_on // internal d-plus pull-up
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rst_q;
   logic rst_n;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // ----------------------------------------
   // gasket decode
   // ----------------------------------------
   logic cpu_ram;
   assign cpu_ram = cpu_req && !cpu_addr[`USBBRM_REG_SEL_BIT];
   assign reg_sel = cpu_req && cpu_addr[`USBBRM_REG_SEL_BIT];
   assign reg_we = reg_sel && cpu_we;
   assign reg_addr = cpu_addr[7:0];
   assign reg_wdata = cpu_wdata;

   // ----------------------------------------
   // descriptor position
   // ----------------------------------------
   // index order, then three bytes each
   function automatic logic [7:0] desc_base(
      input logic [2:0] ep,
      input logic in_dir,
      input logic odd
   );
      logic [3:0] idx;
      idx = 4'h0;
      if (ep == 3'h0) begin
         idx = in_dir ? 4'h0 : 4'h1;
      end else if (ep <= 3'h4) begin
         idx = {1'b0, ep} + 4'h1;
      end else begin
         idx = {ep, 1'b0} - 4'h4 + {3'h0, odd};
      end
      desc_base = 8'({4'h0, idx} * `USBBRM_DESC_BYTES);
   endfunction

   // ----------------------------------------
   // descriptor state machine
   // ----------------------------------------
   usbbrm_pkg::usbbrm_state_e st_q, st_d;
   logic [7:0] base_q, base_d;
   logic [7:0] stat_q, stat_d;
   logic [7:0] cnt_q, cnt_d;
   logic [7:0] adr_q, adr_d;
   logic in_q, in_d;
   logic [7:0] sl_addr;
   logic sl_we;
   logic [7:0] sl_wdata;
   logic [7:0] se_q;
   logic tok_ok;

   assign tok_ok = tok_valid && tok_ready && tok_ep <= `USBBRM_MAX_EP
      && ep_en[tok_ep];
   assign tok_ready = usb_enable && st_q == usbbrm_pkg::ST_IDLE;
   assign se_ready = st_q == usbbrm_pkg::ST_BUSY;
   assign bd_valid = st_q == usbbrm_pkg::ST_CHK;
   assign bd_status = stat_q;
   assign bd_count = cnt_q;
   assign bd_addr = adr_q;
   // own clear leaves buffer to the cpu
   assign bd_own = stat_q[`USBBRM_OWN_BIT];
   assign bd_stall = stat_q[`USBBRM_STALL_BIT];
   // buffers must lie above the reserved pair
   assign bd_addr_ok = adr_q >= `USBBRM_BUF_BASE;

   always_comb begin
      st_d = st_q;
      base_d = base_q;
      stat_d = stat_q;
      cnt_d = cnt_q;
      adr_d = adr_q;
      in_d = in_q;
      sl_addr = base_q;
      sl_we = 1'b0;
      sl_wdata = `USBBRM_RST_BYTE;
      unique case (st_q)
         usbbrm_pkg::ST_IDLE: begin
            if (tok_ok) begin
               base_d = desc_base(tok_ep, tok_in, tok_odd);
               in_d = tok_in;
               st_d = usbbrm_pkg::ST_RD0;
            end
         end
         usbbrm_pkg::ST_RD0: begin
            st_d = usbbrm_pkg::ST_RD1;
         end
         usbbrm_pkg::ST_RD1: begin
            sl_addr = base_q + 8'h01;
            stat_d = se_q;
            st_d = usbbrm_pkg::ST_RD2;
         end
         usbbrm_pkg::ST_RD2: begin
            sl_addr = base_q + 8'h02;
            cnt_d = se_q;
            st_d = usbbrm_pkg::ST_LAT;
         end
         usbbrm_pkg::ST_LAT: begin
            adr_d = {se_q[5:0], 2'h0};
            st_d = usbbrm_pkg::ST_CHK;
         end
         usbbrm_pkg::ST_CHK: begin
            // only an owned, unstalled entry is used
            if (bd_own && !bd_stall && bd_addr_ok) begin
               st_d = usbbrm_pkg::ST_BUSY;
            end else begin
               st_d = usbbrm_pkg::ST_IDLE;
            end
         end
         usbbrm_pkg::ST_BUSY: begin
            sl_addr = se_addr;
            // engine data writes confined to buffers
            sl_we = se_req && se_we && se_addr >= `USBBRM_BUF_BASE;
            sl_wdata = se_wdata;
            if (tok_done) begin
               if (!in_q) begin
                  cnt_d = done_count;
               end
               st_d = usbbrm_pkg::ST_WB;
            end
         end
         usbbrm_pkg::ST_WB: begin
            // hand descriptor back with own cleared
            sl_we = 1'b1;
            sl_wdata = stat_q & 8'h7f;
            stat_d = stat_q & 8'h7f;
            st_d = in_q ? usbbrm_pkg::ST_IDLE : usbbrm_pkg::ST_RD0;
         end
      endcase
      if (!usb_enable) begin
         st_d = usbbrm_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= usbbrm_pkg::ST_IDLE;
         base_q <= `USBBRM_RST_BYTE;
         stat_q <= `USBBRM_RST_BYTE;
         cnt_q <= `USBBRM_RST_BYTE;
         adr_q <= `USBBRM_RST_BYTE;
         in_q <= 1'b0;
      end else begin
         st_q <= st_d;
         base_q <= base_d;
         stat_q <= stat_d;
         cnt_q <= cnt_d;
         adr_q <= adr_d;
         in_q <= in_d;
      end
   end

   // ----------------------------------------
   // shared ram, two slots per bus clock
   // ----------------------------------------
   // out tokens store the count through its own write below; the
   // descriptor is then fetched again so the outputs show the result
   logic [7:0] mem [`USBBRM_RAM_BYTES];
   logic cnt_wb;
   logic [7:0] cpu_rdata_d;
   assign cnt_wb = st_q == usbbrm_pkg::ST_WB && !in_q;

   always_comb begin
      cpu_rdata_d = cpu_rdata;
      if (reg_sel && !cpu_we) begin
         cpu_rdata_d = reg_rdata;
      end else if (cpu_ram && !cpu_we) begin
         cpu_rdata_d = mem[cpu_addr[7:0]];
      end
   end

   // first slot cpu, second slot engine
   // engine slot wins a same-address clash
   always_ff @(posedge mclk) begin
      if (cpu_ram && cpu_we) begin
         mem[cpu_addr[7:0]] <= cpu_wdata;
      end
      if (sl_we) begin
         mem[sl_addr] <= sl_wdata;
      end
      if (cnt_wb) begin
         mem[base_q + 8'h01] <= cnt_q;
      end
   end

   // registered read ports for both sides
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         se_q <= `USBBRM_RST_BYTE;
         cpu_rdata <= `USBBRM_RST_BYTE;
      end else begin
         se_q <= mem[sl_addr];
         cpu_rdata <= cpu_rdata_d;
      end
   end
   assign se_rdata = se_q;

   // ----------------------------------------
   // regulator and pull-up
   // ----------------------------------------
   usbbrm_pkg::usbbrm_usb_regulator_e vr_q, vr_d;
   logic pu_q, pu_d;
   always_comb begin
      if (deep_stop || !usb_regulator_enable) begin
         vr_d = usbbrm_pkg::VR_OFF;
      end else if (usb_suspend) begin
         vr_d = usbbrm_pkg::VR_STANDBY;
      end else begin
         vr_d = usbbrm_pkg::VR_ACTIVE;
      end
      pu_d = internal_pullup_enable;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vr_q <= usbbrm_pkg::VR_OFF;
         pu_q <= 1'b0;
      end else begin
         vr_q <= vr_d;
         pu_q <= pu_d;
      end
   end
   assign usb_regulator_mode = vr_q;
   assign dp_pullup_on = pu_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   route_split_a: assert property (reg_sel |-> !cpu_ram)
      else $error("register access reached the ram");
   cpu_write_a: assert property (
      cpu_ram && cpu_we && !(sl_we && sl_addr == cpu_addr[7:0])
      && !cnt_wb |=> mem[$past(cpu_addr[7:0])] == $past(cpu_wdata))
      else $error("cpu write not stored");
   fetch_time_a: assert property (
      tok_ok ##1 usb_enable [*4] |=> bd_valid)
      else $error("descriptor not fetched in five cycles");
   table_range_a: assert property (
      st_q == usbbrm_pkg::ST_RD0 |-> base_q <= 8'h1b)
      else $error("descriptor outside table");
   order_map_a: assert property (
      tok_ok && tok_ep == 3'h6 && tok_odd |=> base_q == 8'h1b)
      else $error("ep6 odd descriptor misplaced");
   own_release_a: assert property (
      usb_enable && st_q == usbbrm_pkg::ST_BUSY && tok_done
      |=> sl_we && !sl_wdata[7] && sl_addr == base_q)
      else $error("own bit not released");
   unowned_skip_a: assert property (
      bd_valid && !bd_own |=> st_q == usbbrm_pkg::ST_IDLE)
      else $error("unowned descriptor used");
   rsv_guard_a: assert property (
      st_q == usbbrm_pkg::ST_BUSY && se_addr < 8'h20 |-> !sl_we)
      else $error("engine wrote below buffer area");
   disable_idle_a: assert property (
      !usb_enable |=> st_q == usbbrm_pkg::ST_IDLE)
      else $error("disabled module still active");
   usb_regulator_mode_a: assert property (
      deep_stop |=> usb_regulator_mode == usbbrm_pkg::VR_OFF)
      else $error("regulator not off in deep stop");
   usb_regulator_sby_a: assert property (
      usb_regulator_enable && !deep_stop && usb_suspend
      |=> usb_regulator_mode == usbbrm_pkg::VR_STANDBY)
      else $error("regulator not in standby");
   pullup_a: assert property (
      ##1 dp_pullup_on == $past(internal_pullup_enable))
      else $error("pull-up does not follow enable");

   fetch_owned_c: cover property (bd_valid && bd_own && !bd_stall);
   fetch_free_c: cover property (bd_valid && !bd_own);
   stall_c: cover property (bd_valid && bd_own && bd_stall);
   release_c: cover property (st_q == usbbrm_pkg::ST_WB);
endmodule

// ---- design/usbbrm_pkg.sv ----
// types for the usb buffer ram and descriptor manager
package usbbrm_pkg;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_RD0 = 8'h02,
      ST_RD1 = 8'h04,
      ST_RD2 = 8'h08,
      ST_LAT = 8'h10,
      ST_CHK = 8'h20,
      ST_BUSY = 8'h40,
      ST_WB = 8'h80
   } usbbrm_state_e;
   typedef enum logic [2:0] {
      VR_ACTIVE = 3'h1,
      VR_STANDBY = 3'h2,
      VR_OFF = 3'h4
   } usbbrm_usb_regulator_e;
endpackage

// ---- design/usbbrm_regs.svh ----
// constants for the usb buffer ram and descriptor manager
`ifndef USBBRM_REGS_SVH
`define USBBRM_REGS_SVH
// ----------------------------------------
// buffer ram map
// ----------------------------------------
`define USBBRM_RAM_BYTES 256
`define USBBRM_TBL_BASE 8'h00
`define USBBRM_TBL_LAST 8'h1d
`define USBBRM_RSV_LO 8'h1e
`define USBBRM_RSV_HI 8'h1f
`define USBBRM_BUF_BASE 8'h20
`define USBBRM_BUF_LAST 8'hff
`define USBBRM_DESC_BYTES 8'h03
// ----------------------------------------
// descriptor status byte fields
// ----------------------------------------
`define USBBRM_OWN_BIT 7
`define USBBRM_STALL_BIT 2
// ----------------------------------------
// cpu address decode
// ----------------------------------------
`define USBBRM_REG_SEL_BIT 8
`define USBBRM_MAX_EP 3'h6
`define USBBRM_RST_BYTE 8'h00
`endif

// ---- test/tb_top.sv ----
// self-checking bench for the usb buffer ram and descriptor manager
`timescale 1ns/1ps
module tb_top;
   logic mclk, arst_n, usb_enable, cpu_req, cpu_we, tok_valid, tok_in;
   logic tok_odd, se_req, se_we, tok_done, usb_regulator_enable, usb_suspend;
   logic deep_stop, internal_pullup_enable, reg_sel, reg_we, tok_ready;
   logic bd_valid, bd_own, bd_stall, bd_addr_ok, se_ready, dp_pullup_on;
   logic [8:0] cpu_addr;
   logic [7:0] cpu_wdata, cpu_rdata, reg_addr, reg_wdata, reg_rdata;
   logic [7:0] bd_status, bd_count, bd_addr, se_addr, se_wdata, se_rdata;
   logic [7:0] done_count, rd;
   logic [6:0] ep_en;
   logic [2:0] tok_ep, usb_regulator_mode;
   int error_cnt = 0;
   int cmp_count = 0;
   // rows: cpu address, byte written and read back
   logic [16:0] mrow [0:6] = '{17'h0_0011, 17'h0_1d22, 17'h0_1e33,
      17'h0_2044, 17'h0_ff55, 17'h1_0566, 17'h0_0577};
   // rows: endpoint, in, odd in descriptor table order
   logic [4:0] trow [0:9] = '{5'h02, 5'h00, 5'h04, 5'h08, 5'h0c, 5'h10,
      5'h14, 5'h15, 5'h18, 5'h19};
   // rows: enable, suspend, deep stop, expected regulator mode
   // suspend never comes together with deep stop
   logic [5:0] vrow [0:4] = '{6'h04, 6'h14, 6'h2c, 6'h32, 6'h21};

   usbbrm_core uut (.*);
   usbbrm_se_model se_model (.*);

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cpu(input logic w, input logic [8:0] a, input logic [7:0] d);
      cpu_req = 1'b1;
      cpu_we = w;
      cpu_addr = a;
      cpu_wdata = d;
      @(negedge mclk);
      rd = cpu_rdata;
      cpu_req = 1'b0;
      cpu_we = 1'b0;
      // one idle edge keeps back-to-back calls from retoggling the strobe
      @(negedge mclk);
   endtask

   task automatic tok(input logic [4:0] t);
      int n;
      tok_ep = t[4:2];
      tok_in = t[1];
      tok_odd = t[0];
      tok_valid = 1'b1;
      @(negedge mclk);
      tok_valid = 1'b0;
      n = 0;
      while (bd_valid !== 1'b1 && n < 10) begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (tok_ready !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
   endtask

   // owner byte is written last so the descriptor is whole when handed over
   task automatic run(input logic [4:0] t, input logic [7:0] b, s, c, a);
      logic [7:0] ea;
      ea = {a[5:0], 2'b00};
      cpu(1'b1, {1'b0, b + 8'h01}, c);
      cpu(1'b1, {1'b0, b + 8'h02}, a);
      cpu(1'b1, {1'b0, b}, s);
      tok(t);
      chk("bd_valid", 8'h01, 8'(bd_valid));
      chk("bd_status", s, bd_status);
      chk("bd_count", c, bd_count);
      chk("bd_addr", ea, bd_addr);
      chk("bd_own", 8'(s[7]), 8'(bd_own));
      chk("bd_stall", 8'(s[2]), 8'(bd_stall));
      chk("bd_addr_ok", 8'(ea >= 8'h20), 8'(bd_addr_ok));
      @(negedge mclk);
      chk("se_ready", 8'(s[7] & ~s[2] & (ea >= 8'h20)), 8'(se_ready));
   endtask

   initial begin
      #(100 * 20000);
      error_cnt++;
      end_of_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      arst_n = 1'b0;
      usb_enable = 1'b1;
      {cpu_req, cpu_we, tok_valid, tok_in, tok_odd, se_req, se_we} = '0;
      {tok_done, usb_suspend, deep_stop, internal_pullup_enable} = '0;
      {cpu_addr, cpu_wdata, se_addr, se_wdata, done_count, tok_ep} = '0;
      usb_regulator_enable = 1'b1;
      ep_en = 7'h7f;
      repeat (8) @(negedge mclk);
      chk("usb_regulator_mode", 8'h04, 8'(usb_regulator_mode));
      chk("dp_pullup_on", 8'h00, 8'(dp_pullup_on));
      arst_n = 1'b1;
      repeat (3) @(negedge mclk);
      for (int i = 0; i < 7; i++) begin
         cpu(1'b1, mrow[i][16:8], mrow[i][7:0]);
      end
      for (int i = 0; i < 7; i++) begin
         cpu(1'b0, mrow[i][16:8], 8'h00);
         chk("cpu_rdata", mrow[i][7:0], rd);
      end
      for (int i = 0; i < 10; i++) begin
         run(trow[i], 8'(i * 3), 8'h00, 8'(8'h30 + i), 8'(8'h08 + i));
      end
      for (int i = 0; i < 5; i++) begin
         {usb_regulator_enable, usb_suspend, deep_stop} = vrow[i][5:3];
         repeat (2) @(negedge mclk);
         chk("usb_regulator_mode", 8'(vrow[i][2:0]), 8'(usb_regulator_mode));
      end
      usb_regulator_enable = 1'b1;
      usb_suspend = 1'b0;
      deep_stop = 1'b0;
      // vbus taken as sensed before the pull-up
      internal_pullup_enable = 1'b1;
      repeat (2) @(negedge mclk);
      chk("dp_pullup_on", 8'h01, 8'(dp_pullup_on));
      internal_pullup_enable = 1'b0;
      repeat (2) @(negedge mclk);
      chk("dp_pullup_on", 8'h00, 8'(dp_pullup_on));
      // in token on ep5 odd with engine and cpu in the same cycle
      cpu(1'b1, 9'h010, 8'h5a);
      run(5'h17, 8'h15, 8'h80, 8'h10, 8'h10);
      {se_req, se_we, se_addr, se_wdata} = {2'b11, 16'h40a5};
      {cpu_req, cpu_we, cpu_addr, cpu_wdata} = {2'b11, 9'h050, 8'h3c};
      @(negedge mclk);
      cpu_req = 1'b0;
      {se_addr, se_wdata} = 16'h10ee;
      @(negedge mclk);
      {se_we, se_addr} = {1'b0, 8'h40};
      @(negedge mclk);
      se_req = 1'b0;
      chk("se_rdata", 8'ha5, se_rdata);
      tok_done = 1'b1;
      @(negedge mclk);
      tok_done = 1'b0;
      wait_idle();
      cpu(1'b0, 9'h015, 8'h00);
      chk("own_release", 8'h00, rd);
      cpu(1'b0, 9'h040, 8'h00);
      chk("engine_write", 8'ha5, rd);
      cpu(1'b0, 9'h050, 8'h00);
      chk("cpu_write", 8'h3c, rd);
      cpu(1'b0, 9'h010, 8'h00);
      chk("table_guard", 8'h5a, rd);
      // out token on ep0 writes the received count back
      done_count = 8'h07;
      run(5'h00, 8'h03, 8'hc0, 8'h40, 8'h20);
      tok_done = 1'b1;
      @(negedge mclk);
      tok_done = 1'b0;
      wait_idle();
      wait_idle();
      cpu(1'b0, 9'h003, 8'h00);
      chk("out_status", 8'h40, rd);
      cpu(1'b0, 9'h004, 8'h00);
      chk("out_count", 8'h07, rd);
      // stalled and badly placed descriptors are left untouched
      run(5'h08, 8'h09, 8'h84, 8'h00, 8'h18);
      wait_idle();
      cpu(1'b0, 9'h009, 8'h00);
      chk("stall_kept", 8'h84, rd);
      run(5'h18, 8'h18, 8'h80, 8'h00, 8'h05);
      wait_idle();
      ep_en = 7'h77;
      tok(5'h0c);
      chk("bd_valid", 8'h00, 8'(bd_valid));
      tok(5'h1c);
      chk("bd_valid", 8'h00, 8'(bd_valid));
      ep_en = 7'h7f;
      usb_enable = 1'b0;
      @(negedge mclk);
      chk("tok_ready", 8'h00, 8'(tok_ready));
      cpu(1'b1, 9'h030, 8'h96);
      cpu(1'b0, 9'h030, 8'h00);
      chk("sys_mem", 8'h96, rd);
      end_of_test();
   end
endmodule

// ---- test/usbbrm_se_model.sv ----
// behavioural serial engine register space behind the cpu gasket
`timescale 1ns/1ps
module usbbrm_se_model (
   input wire logic mclk, // bus clock
   input wire logic reg_sel, // register access selected
   input wire logic reg_we, // register write
   input wire logic [7:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // register write data
   output logic [7:0] reg_rdata // register read data
);
   logic [7:0] regs [0:15];
   logic [7:0] last_q;
   // engine register space
   // unselected bus shows the inverse of the last value, so a stale
   // read can never pass for a correct one
   assign reg_rdata = reg_sel ? regs[reg_addr[3:0]] : ~last_q;
   always_ff @(posedge mclk) begin
      if (reg_we) begin
         regs[reg_addr[3:0]] <= reg_wdata;
      end
      if (reg_sel) begin
         last_q <= reg_rdata;
      end
   end
endmodule
